// *** logic/mdx_pkg.sv ***
// mdx_pkg: shared constants and carriers for the instruction decode/execute core
// assumes one core clock; every instruction cycle is four core clocks
package mdx_pkg;
    localparam int InstrWidth   = 14;
    localparam int PcWidth      = 13;
    localparam int FileAddrW    = 7;
    localparam int StackDepth   = 8;
    localparam int StackPtrW    = 3;
    localparam int PhaseCount   = 4;
    // instruction field positions
    localparam int ClassHi      = 13;
    localparam int ClassLo      = 12;
    localparam int OpHi         = 11;
    localparam int OpLo         = 8;
    localparam int DestBit      = 7;
    localparam int BitSelHi     = 9;
    localparam int BitSelLo     = 7;
    localparam int JumpSelBit   = 11;
    // special file addresses
    localparam logic [6:0] TickAddr = 7'h01;
    localparam logic [6:0] PortAddr = 7'h06;
    // reset values
    localparam logic [12:0] PcReset   = 13'h0000;
    localparam logic [7:0]  ByteReset = 8'h00;
    // instruction classes from the two top bits
    typedef enum logic [1:0] {
        CLS_BYTE = 2'b00,
        CLS_BIT  = 2'b01,
        CLS_JUMP = 2'b10,
        CLS_LIT  = 2'b11
    } mdx_class_type;
    // arithmetic flags
    typedef struct packed {
        logic carry;
        logic digitCarry;
        logic zero;
    } mdx_flags_type;
    // one-clock control pulses towards the rest of the device
    typedef struct packed {
        logic sleepReq;
        logic watchdogClear;
        logic intReturn;
        logic prescalerClear;
    } mdx_ctrl_type;
endpackage

// *** logic/mdx_quad_phase.sv ***
// mdx_quad_phase: splits the core clock into four phases of an instruction cycle
// assumes a synchronous active-high reset on the same clock
`timescale 1ns/1ps
module mdx_quad_phase
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    output logic [1:0]      phase,
    output logic            cycleEnd
);
    logic [1:0] phase_q;

    // free-running phase count, restarts at phase 0 after reset
    always_ff @(posedge core_clk)
    begin
        if (rst)
            phase_q <= 2'h0;
        else
            phase_q <= phase_q + 2'h1;
    end

    assign phase    = phase_q;
    assign cycleEnd = (phase_q == 2'(mdx_pkg::PhaseCount - 1));
endmodule // mdx_quad_phase

// *** logic/mdx_file_ram.sv ***
// mdx_file_ram: general file register storage, 128 bytes
// read data comes from a register one clock after the address
`timescale 1ns/1ps
module mdx_file_ram
(
    input  wire logic       core_clk,
    input  wire logic       we,
    input  wire logic [6:0] wAddr,
    input  wire logic [7:0] wData,
    input  wire logic [6:0] rAddr,
    output logic [7:0]      rData
);
    logic [7:0] mem [0:(1 << mdx_pkg::FileAddrW) - 1];
    logic [7:0] rData_q;

    // contents are undefined after reset, as in the real file
    always_ff @(posedge core_clk)
    begin
        if (we)
            mem[wAddr] <= wData;
        rData_q <= mem[rAddr];
    end

    assign rData = rData_q;
endmodule // mdx_file_ram

// *** logic/mdx_core.sv ***
// mdx_core: instruction decode and execution control of a small 8-bit core
// assumes program memory answers progAddr combinationally; port pins are asynchronous
`timescale 1ns/1ps
// How it works
// - every instruction is one 14-bit word: opcode plus operand fields
// - three classes: byte file ops, bit file ops, literal and control ops
// - byte ops: destination bit 0 writes the accumulator, 1 writes the file
// - the file selector is a 7-bit direct address, 0x00 to 0x7f
// - bit ops change only the selected bit of the named 8-bit register
// - literal field is 8 bits for data, 11 bits for jumps and calls
// - one instruction cycle is four core clock periods
// - taken skips and program counter changes add a second cycle run as nop
// - any instruction naming a file register reads it before modifying and storing
// - clearing the port reads it, refreshing the change comparison
// - don't-care opcode bits are ignored by the decoder
// - one working register is the implied source and the d=0 destination
// - port read-modify-write takes the pin levels, not the output latch
// - writing the tick counter clears its prescaler when assigned to it
module mdx_core
(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    output logic [12:0]               progAddr,
    input  wire logic [13:0]          instrWord,
    input  wire logic [7:0]           portPins,
    output logic [7:0]                portLatch,
    output logic                      portChange,
    input  wire logic                 tickStep,
    input  wire logic                 prescalerToTick,
    output logic [7:0]                accum,
    output mdx_pkg::mdx_flags_type    flags,
    output mdx_pkg::mdx_ctrl_type     ctrl
);
    logic [1:0]  phase;
    logic        cycleEnd;
    logic [13:0] ir_q;
    logic        execNop_q;
    logic [12:0] pc_q;
    logic [7:0]  w_q;
    logic [7:0]  opnd_q;
    logic [7:0]  res_q;
    logic [7:0]  ramRData;
    logic [7:0]  pinsMeta_q;
    logic [7:0]  pinsSync_q;
    logic [7:0]  portSnap_q;
    logic [7:0]  portLatch_q;
    logic        portChange_q;
    logic [7:0]  tick_q;
    logic [12:0] stack_q [0:mdx_pkg::StackDepth - 1];
    logic [2:0]  sp_q;
    mdx_pkg::mdx_flags_type flags_q;
    mdx_pkg::mdx_flags_type flags_d;
    mdx_pkg::mdx_ctrl_type  ctrl_q;
    mdx_pkg::mdx_class_type cls;
    logic [3:0]  op;
    logic [6:0]  fAddr;
    logic [2:0]  bitSel;
    logic        readsFile;
    logic        toFile;
    logic        toW;
    logic        updZ;
    logic        updC;
    logic        updDc;
    logic        skipIfZero;
    logic        doJump;
    logic        doCall;
    logic        doPop;
    logic        testBit;
    logic        testSense;
    logic [7:0]  res_d;
    logic        rdStrobe;
    logic        wrPhase;
    logic        ramWe;
    logic        wWe;
    logic        takeSkip;
    logic        pcChange;
    logic [8:0]  sum9;
    logic [4:0]  sum5;

    mdx_quad_phase u_phase
    (
        .core_clk (core_clk),
        .rst      (rst),
        .phase    (phase),
        .cycleEnd (cycleEnd)
    );

    // operand fields of the word under execution
    assign cls    = mdx_pkg::mdx_class_type'(ir_q[mdx_pkg::ClassHi:mdx_pkg::ClassLo]);
    assign op     = ir_q[mdx_pkg::OpHi:mdx_pkg::OpLo];
    assign fAddr  = ir_q[mdx_pkg::FileAddrW - 1:0];
    assign bitSel = ir_q[mdx_pkg::BitSelHi:mdx_pkg::BitSelLo];

    // decode; compares leave out don't-care bits, so they take either value
    always_comb
    begin
        readsFile  = 1'b0;
        toFile     = 1'b0;
        toW        = 1'b0;
        updZ       = 1'b0;
        updC       = 1'b0;
        updDc      = 1'b0;
        skipIfZero = 1'b0;
        doJump     = 1'b0;
        doCall     = 1'b0;
        doPop      = 1'b0;
        testBit    = 1'b0;
        testSense  = 1'b0;
        case (cls)
            mdx_pkg::CLS_BYTE:
            begin
                if (op == 4'h0)
                begin
                    // move w to f, or the no-operand control group
                    readsFile = ir_q[mdx_pkg::DestBit];
                    toFile    = ir_q[mdx_pkg::DestBit];
                    doPop     = !ir_q[mdx_pkg::DestBit] && (ir_q[6:1] == 6'h04);
                end
                else
                begin
                    readsFile = (op != 4'h1) || ir_q[mdx_pkg::DestBit];
                    toFile    = ir_q[mdx_pkg::DestBit];
                    toW       = !ir_q[mdx_pkg::DestBit];
                    updZ      = (op != 4'hb) && (op != 4'hf) && (op != 4'he)
                                && (op != 4'hd) && (op != 4'hc);
                    updC      = (op == 4'h7) || (op == 4'h2) || (op == 4'hd)
                                || (op == 4'hc);
                    updDc     = (op == 4'h7) || (op == 4'h2);
                    skipIfZero = (op == 4'hb) || (op == 4'hf);
                end
            end
            mdx_pkg::CLS_BIT:
            begin
                readsFile = 1'b1;
                toFile    = !op[3];
                testBit   = op[3];
                testSense = op[2];
            end
            mdx_pkg::CLS_JUMP:
            begin
                doJump = 1'b1;
                doCall = !ir_q[mdx_pkg::JumpSelBit];
            end
            default:
            begin
                // literal data ops always land in w
                toW   = 1'b1;
                doPop = (op[3:2] == 2'b01);
                updZ  = op[3];
                updC  = (op[3:2] == 2'b11);
                updDc = (op[3:2] == 2'b11);
            end
        endcase
    end

    // arithmetic and logic of the modify step
    always_comb
    begin
        res_d   = opnd_q;
        flags_d = flags_q;
        sum9    = 9'h000;
        sum5    = 5'h00;
        if (cls == mdx_pkg::CLS_BYTE)
        begin
            case (op)
                4'h0: res_d = w_q;
                4'h1: res_d = mdx_pkg::ByteReset;
                4'h2:
                begin
                    sum9 = {1'b0, opnd_q} + {1'b0, ~w_q} + 9'h001;
                    sum5 = {1'b0, opnd_q[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
                end
                4'h3: res_d = opnd_q - 8'h01;
                4'h4: res_d = opnd_q | w_q;
                4'h5: res_d = opnd_q & w_q;
                4'h6: res_d = opnd_q ^ w_q;
                4'h7:
                begin
                    sum9 = {1'b0, opnd_q} + {1'b0, w_q};
                    sum5 = {1'b0, opnd_q[3:0]} + {1'b0, w_q[3:0]};
                end
                4'h9: res_d = ~opnd_q;
                4'ha: res_d = opnd_q + 8'h01;
                4'hb: res_d = opnd_q - 8'h01;
                4'hc: {res_d, flags_d.carry} = {flags_q.carry, opnd_q};
                4'hd: {flags_d.carry, res_d} = {opnd_q, flags_q.carry};
                4'he: res_d = {opnd_q[3:0], opnd_q[7:4]};
                4'hf: res_d = opnd_q + 8'h01;
                default: res_d = opnd_q;
            endcase
        end
        else if (cls == mdx_pkg::CLS_BIT)
        begin
            res_d[bitSel] = op[2];
        end
        else if (cls == mdx_pkg::CLS_LIT)
        begin
            casez (op)
                4'b00??: res_d = ir_q[7:0];
                4'b01??: res_d = ir_q[7:0];
                4'b1000: res_d = w_q | ir_q[7:0];
                4'b1001: res_d = w_q & ir_q[7:0];
                4'b1010: res_d = w_q ^ ir_q[7:0];
                4'b110?:
                begin
                    sum9 = {1'b0, ir_q[7:0]} + {1'b0, ~w_q} + 9'h001;
                    sum5 = {1'b0, ir_q[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
                end
                4'b111?:
                begin
                    sum9 = {1'b0, ir_q[7:0]} + {1'b0, w_q};
                    sum5 = {1'b0, ir_q[3:0]} + {1'b0, w_q[3:0]};
                end
                default: res_d = w_q;
            endcase
        end
        if (updDc)
        begin
            res_d              = sum9[7:0];
            flags_d.carry      = sum9[8];
            flags_d.digitCarry = sum5[4];
        end
        if (updZ)
            flags_d.zero = (res_d == 8'h00);
        // only the carry-writing ops may move carry; every other op keeps it
        if (!updC)
            flags_d.carry = flags_q.carry;
    end

    // phase roles: read at phase 1, modify at 2, store at 3
    assign rdStrobe = (phase == 2'h1) && readsFile && !execNop_q;
    assign wrPhase  = cycleEnd && !execNop_q;
    assign ramWe    = wrPhase && toFile && (fAddr != mdx_pkg::TickAddr)
                      && (fAddr != mdx_pkg::PortAddr);
    assign wWe      = wrPhase && toW;
    assign takeSkip = (skipIfZero && (res_q == 8'h00))
                      || (testBit && (opnd_q[bitSel] == testSense));
    assign pcChange = doJump || doPop;

    mdx_file_ram u_ram
    (
        .core_clk (core_clk),
        .we       (ramWe),
        .wAddr    (fAddr),
        .wData    (res_q),
        .rAddr    (fAddr),
        .rData    (ramRData)
    );

    // port pins are asynchronous, two flops before use
    always_ff @(posedge core_clk)
    begin
        pinsMeta_q <= portPins;
        pinsSync_q <= pinsMeta_q;
    end

    // read and modify steps
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            opnd_q <= mdx_pkg::ByteReset;
            res_q  <= mdx_pkg::ByteReset;
        end
        else
        begin
            if (rdStrobe)
            begin
                if (fAddr == mdx_pkg::PortAddr)
                    opnd_q <= pinsSync_q;
                else if (fAddr == mdx_pkg::TickAddr)
                    opnd_q <= tick_q;
                else
                    opnd_q <= ramRData;
            end
            else if (phase == 2'h1)
                opnd_q <= mdx_pkg::ByteReset;
            if (phase == 2'h2)
                res_q <= res_d;
        end
    end

    // working register stored at the cycle end, flags stored at phase 2
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            w_q     <= mdx_pkg::ByteReset;
            flags_q <= '0;
        end
        else
        begin
            if (wWe)
                w_q <= res_q;
            if (phase == 2'h2 && !execNop_q)
                flags_q <= flags_d;
        end
    end

    // port latch and change comparison; a read refreshes the snapshot
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            portLatch_q  <= mdx_pkg::ByteReset;
            portSnap_q   <= mdx_pkg::ByteReset;
            portChange_q <= 1'b0;
        end
        else
        begin
            if (wrPhase && toFile && fAddr == mdx_pkg::PortAddr)
                portLatch_q <= res_q;
            if (rdStrobe && fAddr == mdx_pkg::PortAddr)
                portSnap_q <= pinsSync_q;
            portChange_q <= (pinsSync_q != portSnap_q);
        end
    end

    // tick counter: a store replaces the count and clears the prescaler when it is assigned to the counter
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tick_q <= mdx_pkg::ByteReset;
            ctrl_q <= '0;
        end
        else
        begin
            ctrl_q <= '0;
            if (wrPhase && toFile && fAddr == mdx_pkg::TickAddr)
            begin
                tick_q                <= res_q;
                ctrl_q.prescalerClear <= prescalerToTick;
            end
            else if (tickStep)
                tick_q <= tick_q + 8'h01;
            if (wrPhase && cls == mdx_pkg::CLS_BYTE && op == 4'h0 && !ir_q[7])
            begin
                ctrl_q.sleepReq      <= (ir_q[6:0] == 7'h63);
                ctrl_q.watchdogClear <= (ir_q[6:0] == 7'h64);
                ctrl_q.intReturn     <= (ir_q[6:0] == 7'h09);
            end
        end
    end

    // fetch and program flow; a flushed fetch runs as a nop next cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pc_q      <= mdx_pkg::PcReset;
            ir_q      <= 14'h0000;
            execNop_q <= 1'b1;
            sp_q      <= 3'h0;
        end
        else if (cycleEnd)
        begin
            ir_q      <= instrWord;
            execNop_q <= !execNop_q && (pcChange || takeSkip);
            if (!execNop_q && doJump)
                pc_q <= {pc_q[12:11], ir_q[10:0]};
            else if (!execNop_q && doPop)
                pc_q <= stack_q[sp_q - 3'h1];
            else
                pc_q <= pc_q + 13'h0001;
            if (!execNop_q && doCall)
            begin
                stack_q[sp_q] <= pc_q;
                sp_q          <= sp_q + 3'h1;
            end
            else if (!execNop_q && doPop)
                sp_q <= sp_q - 3'h1;
        end
    end

    assign progAddr   = pc_q;
    assign portLatch  = portLatch_q;
    assign portChange = portChange_q;
    assign accum      = w_q;
    assign flags      = flags_q;
    assign ctrl       = ctrl_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence sFetchEnd;
        cycleEnd;
    endsequence

    a_cycle_four: assert property (sFetchEnd |=> !cycleEnd [*3] ##1 cycleEnd)
        else $error("instruction cycle is not four clocks");
    a_flush_nop: assert property (sFetchEnd ##0 (!execNop_q && pcChange) |=> execNop_q)
        else $error("changed program counter not followed by nop cycle");
    // a taken skip that stores to the tick counter pulses the clear as the nop begins
    a_nop_quiet: assert property (execNop_q
        |-> !ramWe && !wWe && !(ctrl_q.prescalerClear && $past(execNop_q)))
        else $error("nop cycle wrote a register");
    a_read_first: assert property (ramWe |-> $past(rdStrobe, 2))
        else $error("file store without prior read");
    a_port_refresh: assert property (rdStrobe && fAddr == mdx_pkg::PortAddr
        |=> portSnap_q == $past(pinsSync_q) && opnd_q == $past(pinsSync_q))
        else $error("port read did not take the pins");
    a_presc_clear: assert property (wrPhase && toFile && fAddr == mdx_pkg::TickAddr
        && prescalerToTick |=> ctrl_q.prescalerClear)
        else $error("tick store kept the prescaler");
    a_dest_sel: assert property (wWe && cls == mdx_pkg::CLS_BYTE |-> !ir_q[7])
        else $error("byte result sent to w with d set");
    a_bit_only: assert property (ramWe && cls == mdx_pkg::CLS_BIT
        |-> ((res_q ^ opnd_q) & ~(8'h01 << bitSel)) == 8'h00)
        else $error("bit op changed other bits");
    a_lit_class: assert property (ir_q[13] |-> !ramWe)
        else $error("literal op stored to a file register");
endmodule // mdx_core

// *** dv/mdx_prog_rom.sv ***
// mdx_prog_rom: behavioural program memory that feeds the core one word per address
// assumes the bench preloads the array; addresses past the array read as nop
`timescale 1ns/1ps
module mdx_prog_rom
(
    input  wire logic [12:0] progAddr,
    output logic [13:0]      instrWord
);
    logic [13:0] mem [0:63];

    // combinational answer; unloaded space gives nop so a runaway pc stays harmless
    assign instrWord = (progAddr < 13'h0040) ? mem[progAddr[5:0]] : 14'h0000;
endmodule // mdx_prog_rom

// *** dv/mcu_instruction_decode_exec_bench.sv ***
// mcu_instruction_decode_exec_bench: runs a fixed program through the core and
// compares every accumulator, port latch, port change and control event in order
// assumes the core fetches combinationally from mdx_prog_rom
`timescale 1ns/1ps
module mcu_instruction_decode_exec_bench;
    typedef struct packed {
        logic [7:0] kind;
        logic [7:0] val;
    } mdx_note_type;

    logic                   core_clk = 1'b0;
    logic                   rst = 1'b1;
    logic [12:0]            progAddr;
    logic [13:0]            instrWord;
    logic [7:0]             portPins = 8'h00;
    logic [7:0]             portLatch;
    logic                   portChange;
    logic                   tickStep = 1'b0;
    logic                   prescalerToTick = 1'b1;
    logic [7:0]             accum;
    mdx_pkg::mdx_flags_type flags;
    mdx_pkg::mdx_ctrl_type  ctrl;
    mdx_note_type           notes [$];
    int                     n_errors = 0;
    int                     n_checks = 0;
    logic [7:0]             p1, p2, prevA, prevL, cnt;
    logic                   prevC, firstEdge;
    logic [2:0]             prevF;
    logic [12:0]            prevPc;

    always #10 core_clk = ~core_clk;

    mdx_core i_dut (.core_clk(core_clk), .rst(rst), .progAddr(progAddr),
        .instrWord(instrWord), .portPins(portPins), .portLatch(portLatch),
        .portChange(portChange), .tickStep(tickStep), .prescalerToTick(prescalerToTick),
        .accum(accum), .flags(flags), .ctrl(ctrl));
    mdx_prog_rom i_rom (.progAddr(progAddr), .instrWord(instrWord));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // kinds: 0 accum, 1 port latch, 2 ctrl pulse, 3 port change level, 4 flags
    task automatic note(input logic [7:0] kind, input logic [7:0] val);
        notes.push_back('{kind, val});
    endtask

    task automatic take(input logic [7:0] kind, input logic [7:0] val);
        mdx_note_type n;
        if (notes.size() == 0)
            check("extra output event", {kind, val}, 16'hffff);
        else
        begin
            n = notes.pop_front();
            check("output event", {kind, val}, {n.kind, n.val});
        end
    endtask

    task automatic wait_addr(input logic [12:0] a);
        int i;
        for (i = 0; i < 400 && progAddr !== a; i++)
            @(posedge core_clk);
        if (progAddr !== a)
        begin
            n_errors++;
            close_out();
        end
    endtask

    // expected events of one pass through the program, in the order they show
    task automatic queue_run(input logic [7:0] pLate, input logic presc);
        note(8'h03, 8'h01);
        note(8'h00, 8'h5a);
        note(8'h04, 8'h01);
        note(8'h00, 8'h00);
        note(8'h04, 8'h00);
        note(8'h00, 8'h5a);
        note(8'h00, 8'hda);
        note(8'h00, 8'hdb);
        note(8'h03, 8'h00);
        note(8'h01, 8'hdb);
        note(8'h04, 8'h01);
        note(8'h00, 8'h00);
        note(8'h03, 8'h01);
        note(8'h03, 8'h00);
        note(8'h01, 8'h00);
        note(8'h04, 8'h00);
        note(8'h00, pLate);
        note(8'h00, 8'h22);
        note(8'h00, 8'h55);
        if (presc)
            note(8'h02, 8'h01);
        note(8'h02, 8'h08);
        note(8'h02, 8'h04);
        note(8'h02, 8'h02);
        note(8'h00, 8'h77);
        note(8'h00, 8'h66);
    endtask

    // bounded wait for the queue to empty, then a quiet stretch for stray events
    task automatic drain();
        int i;
        for (i = 0; i < 1000 && notes.size() != 0; i++)
            @(posedge core_clk);
        check("pending events", 16'(notes.size()), 16'h0000);
        repeat (20) @(posedge core_clk);
    endtask

    // watcher: outputs sampled at the edge are settled values of the previous clock
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt <= 8'h00;
            firstEdge <= 1'b1;
        end
        else
        begin
            if (accum !== prevA) take(8'h00, accum);
            if (portLatch !== prevL) take(8'h01, portLatch);
            if (ctrl !== 4'h0) take(8'h02, {4'h0, ctrl});
            if (portChange !== prevC) take(8'h03, {7'h0, portChange});
            if (flags !== prevF) take(8'h04, {5'h00, flags});
            if (progAddr !== prevPc)
            begin
                if (!firstEdge) check("instruction cycle length", cnt + 8'h01, 8'h04);
                cnt <= 8'h00;
                firstEdge <= 1'b0;
            end
            else
                cnt <= cnt + 8'h01;
        end
        prevA <= accum;
        prevL <= portLatch;
        prevC <= portChange;
        prevF <= flags;
        prevPc <= progAddr;
    end

    // random tick steps keep the counter busy; store wins in its own clock
    always @(posedge core_clk)
        tickStep <= 1'($urandom % 2);

    // hang guard
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        close_out();
    end

    // main sequence: load program, queue expectations, move the pins once per pass
    initial
    begin
        logic [13:0] prog [0:30];
        int i;
        void'($urandom(32'he1ba));
        p1 = 8'($urandom) | 8'h01;
        p2 = ~p1 | 8'h80;
        prog = '{14'h335a, 14'h00a0, 14'h017f, 14'h0820, 14'h17a0, 14'h0820, 14'h0aa0,
                 14'h0820, 14'h0086, 14'h017f, 14'h0000, 14'h0000, 14'h0000, 14'h0186,
                 14'h0806, 14'h1c20, 14'h3011, 14'h3022, 14'h2815, 14'h3033, 14'h3044,
                 14'h3055, 14'h0081, 14'h0063, 14'h0064, 14'h201c, 14'h3066, 14'h281b,
                 14'h201e, 14'h3477, 14'h0009};
        for (i = 0; i < 64; i++)
            i_rom.mem[i] = (i < 31) ? prog[i] : 14'h0000;
        queue_run(p2, 1'b1);
        @(posedge core_clk);
        portPins <= p1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        wait_addr(13'h000b);
        portPins <= p2;
        $display("test port_pins_moved done");
        drain();
        $display("test program_run done");
        // reset in mid-run; the next pass runs with the prescaler elsewhere
        rst <= 1'b1;
        prescalerToTick <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check("progAddr in reset", {3'h0, progAddr}, 16'h0000);
        check("accum in reset", {8'h00, accum}, 16'h0000);
        check("portLatch in reset", {8'h00, portLatch}, 16'h0000);
        check("ctrl in reset", {12'h000, ctrl}, 16'h0000);
        check("flags in reset", {13'h0000, flags}, 16'h0000);
        check("portChange in reset", {15'h0000, portChange}, 16'h0000);
        $display("test second_reset done");
        queue_run(p1, 1'b0);
        @(posedge core_clk);
        rst <= 1'b0;
        wait_addr(13'h000b);
        portPins <= p1;
        drain();
        $display("test tick_unassigned done");
        close_out();
    end
endmodule // mcu_instruction_decode_exec_bench
